// file: pkg/dpw_pkg.sv
// Constants and types for the dual modulator with compare force
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
package dpw_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int DUTY_W = 8;
    localparam int FORCE_N = 5;
    localparam int SEL_W = 3;
    localparam int DIV_W = 7;

    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h24;
    localparam logic [7:0] OFF_DUTY_A = 8'h26;
    localparam logic [7:0] OFF_DUTY_B = 8'h27;
    localparam logic [7:0] OFF_COUNT = 8'h28;
    localparam logic [7:0] OFF_SHADOW_A = 8'h2a;
    localparam logic [7:0] OFF_SHADOW_B = 8'h2b;

    // Control field positions
    localparam int POS_FORCE_LO = 11;
    localparam int POS_FORCE_HI = 15;
    localparam int POS_DISC_A = 9;
    localparam int POS_DISC_B = 8;
    localparam int POS_CLK_OUT = 7;
    localparam int POS_SEL_LO = 4;
    localparam int POS_SEL_HI = 6;
    localparam int POS_PER_A = 3;
    localparam int POS_PER_B = 2;
    localparam int POS_LVL_A = 1;
    localparam int POS_LVL_B = 0;

    // Reset values and codes
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [2:0] SEL_EXT = 3'h7;
    localparam logic [7:0] FAST_END = 8'hff;
    localparam logic [14:0] SLOW_END = 15'h7fff;

    typedef struct packed {
        logic [4:0] compare_force_bits;
        logic reserved;
        logic discrete_select_a;
        logic discrete_select_b;
        logic prescale_clock_out_en;
        logic [2:0] modulator_prescale_sel;
        logic period_length_sel_a;
        logic period_length_sel_b;
        logic forced_level_a;
        logic forced_level_b;
    } dpw_ctrl_t;
endpackage
`default_nettype wire

// file: design/dpw_prescaler.sv
// Prescaler tick and clock-out generator for the modulator counter
`default_nettype none
module dpw_prescaler #(
    parameter int DIV_W = dpw_pkg::DIV_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ext_clk_i,
    input wire logic [2:0] sel_i,
    output logic tick_o,
    output logic clk_level_o
);
    logic [DIV_W-1:0] div_reg;
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic [DIV_W-1:0] mask;
    logic tick_next;
    logic clk_next;

    // ----------------------------------------------------------------
    // Divider chain and external clock synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_clk_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Tick once per 2^(sel+1) cycles, or on a rising external edge
    always_comb begin
        mask = {DIV_W{1'b1}} >> (3'(DIV_W - 1) - sel_i);
        if (sel_i == dpw_pkg::SEL_EXT) begin
            tick_next = sync2_reg & ~sync3_reg;
            clk_next = sync2_reg;
        end else begin
            tick_next = &(div_reg | ~mask);
            clk_next = div_reg[sel_i];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
            clk_level_o <= 1'b0;
        end else begin
            tick_o <= tick_next;
            clk_level_o <= clk_next;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_tick_div_two: assert property (
        (sel_i == 3'h0) ##1 (sel_i == 3'h0) [*2] |-> tick_o != $past(tick_o))
        else $error("divide by two tick does not alternate");
    chk_tick_spacing: assert property (
        tick_o && sel_i == 3'h2 && $past(sel_i) == 3'h2 |=>
        (!tick_o || $past(sel_i) != 3'h2) [*7])
        else $error("divide by eight tick came too early");
    cov_ext_tick: cover property (sel_i == dpw_pkg::SEL_EXT && tick_o);
endmodule
`default_nettype wire

// file: design/dpw_top.sv
// Dual modulator with shared prescaler and compare force strobe
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module dpw_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [15:0] rd_data_o,
    input wire logic ext_prescale_clk_i,
    output logic pwm_a_o,
    output logic pwm_b_o,
    output logic [4:0] compare_force_o
);
    dpw_pkg::dpw_ctrl_t ctrl_reg;
    logic [7:0] duty_a_reg;
    logic [7:0] duty_b_reg;
    logic [7:0] shadow_a_reg;
    logic [7:0] shadow_b_reg;
    logic [15:0] count_reg;
    logic [15:0] rd_data_reg;
    logic [4:0] force_reg;
    logic pin_a_reg;
    logic pin_b_reg;
    logic tick;
    logic presc_clk;
    logic wr_ctrl;
    logic [7:0] slot_a;
    logic [7:0] slot_b;
    logic cmp_a;
    logic cmp_b;
    logic end_a;
    logic end_b;
    logic [15:0] rd_next;

    assign wr_ctrl = wr_en_i && (addr_i == dpw_pkg::OFF_CTRL);

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    dpw_prescaler #(
        .DIV_W(dpw_pkg::DIV_W)
    ) u_presc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ext_clk_i(ext_prescale_clk_i),
        .sel_i(ctrl_reg.modulator_prescale_sel),
        .tick_o(tick),
        .clk_level_o(presc_clk)
    );

    // ----------------------------------------------------------------
    // Control and duty registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= dpw_pkg::RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_reg <= wr_data_i;
            // Force bits are strobes and do not hold
            ctrl_reg.compare_force_bits <= '0;
            ctrl_reg.reserved <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            duty_a_reg <= dpw_pkg::RST_DUTY;
            duty_b_reg <= dpw_pkg::RST_DUTY;
        end else if (wr_en_i) begin
            if (addr_i == dpw_pkg::OFF_DUTY_A) begin
                duty_a_reg <= wr_data_i[7:0];
            end
            if (addr_i == dpw_pkg::OFF_DUTY_B) begin
                duty_b_reg <= wr_data_i[7:0];
            end
        end
    end

    // One-cycle pin action strobes; zero bits do nothing
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            force_reg <= '0;
        end else if (wr_ctrl) begin
            force_reg <= wr_data_i[dpw_pkg::POS_FORCE_HI:
                                   dpw_pkg::POS_FORCE_LO];
        end else begin
            force_reg <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            count_reg <= dpw_pkg::RST_COUNT;
        end else if (tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Comparators and shadow registers
    // ----------------------------------------------------------------
    always_comb begin
        slot_a = ctrl_reg.period_length_sel_a ? count_reg[14:7]
                                              : count_reg[7:0];
        slot_b = ctrl_reg.period_length_sel_b ? count_reg[14:7]
                                              : count_reg[7:0];
        cmp_a = slot_a < shadow_a_reg;
        cmp_b = slot_b < shadow_b_reg;
        end_a = tick && (ctrl_reg.period_length_sel_a
            ? (count_reg[14:0] == dpw_pkg::SLOW_END)
            : (count_reg[7:0] == dpw_pkg::FAST_END));
        end_b = tick && (ctrl_reg.period_length_sel_b
            ? (count_reg[14:0] == dpw_pkg::SLOW_END)
            : (count_reg[7:0] == dpw_pkg::FAST_END));
    end

    // Duty writes reach the comparator only through the shadow
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            shadow_a_reg <= dpw_pkg::RST_DUTY;
            shadow_b_reg <= dpw_pkg::RST_DUTY;
        end else begin
            if (end_a) begin
                shadow_a_reg <= duty_a_reg;
            end
            if (end_b) begin
                shadow_b_reg <= duty_b_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
        end else begin
            if (ctrl_reg.discrete_select_a) begin
                pin_a_reg <= ctrl_reg.forced_level_a;
            end else if (ctrl_reg.prescale_clock_out_en) begin
                pin_a_reg <= presc_clk;
            end else begin
                pin_a_reg <= cmp_a;
            end
            if (ctrl_reg.discrete_select_b) begin
                pin_b_reg <= ctrl_reg.forced_level_b;
            end else begin
                pin_b_reg <= cmp_b;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        rd_next = '0;
        unique case (addr_i)
            dpw_pkg::OFF_CTRL: rd_next = ctrl_reg;
            dpw_pkg::OFF_DUTY_A: rd_next = {8'h00, duty_a_reg};
            dpw_pkg::OFF_DUTY_B: rd_next = {8'h00, duty_b_reg};
            dpw_pkg::OFF_COUNT: rd_next = count_reg;
            dpw_pkg::OFF_SHADOW_A: rd_next = {8'h00, shadow_a_reg};
            dpw_pkg::OFF_SHADOW_B: rd_next = {8'h00, shadow_b_reg};
            default: rd_next = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_data_reg <= '0;
        end else if (rd_en_i) begin
            rd_data_reg <= rd_next;
        end else begin
            rd_data_reg <= '0;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign pwm_a_o = pin_a_reg;
    assign pwm_b_o = pin_b_reg;
    assign compare_force_o = force_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_force_pulse: assert property (
        wr_ctrl |=> compare_force_o == $past(wr_data_i[15:11]) ##1
        ($past(wr_ctrl) || compare_force_o == 5'h00))
        else $error("force strobe wrong or held");
    chk_force_idle: assert property (
        !wr_ctrl |=> compare_force_o == 5'h00)
        else $error("force strobe without write");
    chk_discrete_a: assert property (
        ctrl_reg.discrete_select_a |=>
        pwm_a_o == $past(ctrl_reg.forced_level_a))
        else $error("pin a not at forced level");
    chk_discrete_b: assert property (
        ctrl_reg.discrete_select_b |=>
        pwm_b_o == $past(ctrl_reg.forced_level_b))
        else $error("pin b not at forced level");
    chk_clock_out: assert property (
        !ctrl_reg.discrete_select_a && ctrl_reg.prescale_clock_out_en |=>
        pwm_a_o == $past(presc_clk))
        else $error("pin a does not carry prescaler clock");
    chk_zero_duty: assert property (
        !ctrl_reg.discrete_select_b && shadow_b_reg == 8'h00 |=> !pwm_b_o)
        else $error("zero duty drove pin high");
    chk_full_duty: assert property (
        !ctrl_reg.discrete_select_a && !ctrl_reg.prescale_clock_out_en &&
        !ctrl_reg.period_length_sel_a && shadow_a_reg == 8'hff &&
        count_reg[7:0] == 8'hff |=> !pwm_a_o)
        else $error("full duty stayed high all period");
    chk_shadow_load: assert property (
        end_a |=> shadow_a_reg == $past(duty_a_reg))
        else $error("shadow a missed end of cycle load");
    chk_shadow_hold: assert property (
        !end_b |=> $stable(shadow_b_reg))
        else $error("shadow b changed mid cycle");
    chk_count_step: assert property (
        tick |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("time base did not advance on tick");
    chk_count_hold: assert property (
        !tick |=> $stable(count_reg))
        else $error("time base moved without tick");
    chk_normal_b: assert property (
        !ctrl_reg.discrete_select_b |=> pwm_b_o == $past(cmp_b))
        else $error("pin b lost modulated waveform");

    cov_force: cover property (compare_force_o != 5'h00);
    cov_shadow_a: cover property (end_a && duty_a_reg != shadow_a_reg);
    cov_clock_out: cover property (ctrl_reg.prescale_clock_out_en && pwm_a_o);
    cov_slow_end: cover property (end_b && ctrl_reg.period_length_sel_b);
endmodule
`default_nettype wire

// file: test/dpw_top_tb.sv
// Self-checking testbench for the dual modulator with compare force
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    n_mismatch++; $display("Error at %0t: got %h expected %h", \
    $time, g, e); end end
module dpw_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 90000;
    logic clk_sys_i;
    logic rst_n_i;
    logic [7:0] addr_i;
    logic [15:0] wr_data_i;
    logic wr_en_i;
    logic rd_en_i;
    logic [15:0] rd_data_o;
    logic ext_prescale_clk_i;
    logic pwm_a_o;
    logic pwm_b_o;
    logic [4:0] compare_force_o;
    int n_mismatch;
    int tests_run;
    int cyc;
    int ha;
    int hb;
    logic [15:0] d;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [7:0] da;
    logic [7:0] db;
    logic [4:0] f;
    logic [1:0] lv;
    logic [7:0] dv [4];
    logic [7:0] ra [6];

    dpw_top DUT (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o),
        .ext_prescale_clk_i(ext_prescale_clk_i),
        .pwm_a_o(pwm_a_o),
        .pwm_b_o(pwm_b_o),
        .compare_force_o(compare_force_o)
    );

    always #4 clk_sys_i = ~clk_sys_i;

    // ------------------------------------------------
    // Bus tasks and expectations
    // ------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= v;
        wr_en_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        #1;
        v = rd_data_o;
    endtask

    task automatic meas(input int n, output int a, output int b);
        a = 0;
        b = 0;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
            a += (pwm_a_o === 1'b1);
            b += (pwm_b_o === 1'b1);
        end
    endtask

    // High clocks in a window that spans whole periods
    function automatic int high_clk(input logic [7:0] duty, input int w);
        return int'(duty) * w / 256;
    endfunction

    function automatic logic [15:0] ticks(input int sel, input int clks);
        return 16'(clks >> (sel + 1));
    endfunction

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        rst_n_i = 1'b0;
        addr_i = 8'h00;
        wr_data_i = 16'h0000;
        wr_en_i = 1'b0;
        rd_en_i = 1'b0;
        ext_prescale_clk_i = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        cyc = 0;
        void'($urandom(44910));
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        ra = '{dpw_pkg::OFF_CTRL, dpw_pkg::OFF_DUTY_A, dpw_pkg::OFF_DUTY_B,
               dpw_pkg::OFF_SHADOW_A, dpw_pkg::OFF_SHADOW_B, 8'h30};
        foreach (ra[i]) begin
            rd(ra[i], d);
            `CHK(d, 16'h0000)
        end
        wr(dpw_pkg::OFF_SHADOW_A, 16'h00a5);
        wr(8'h30, 16'hffff);
        rd(dpw_pkg::OFF_SHADOW_A, d);
        `CHK(d, 16'h0000)
        for (int i = 0; i < 5; i++) begin
            f = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
            c0 = 16'($urandom) & 16'h03ff;
            wr(dpw_pkg::OFF_CTRL, {f, 11'h000} | c0);
            #1;
            `CHK(compare_force_o, f)
            @(posedge clk_sys_i);
            #1;
            `CHK(compare_force_o, 5'h00)
            rd(dpw_pkg::OFF_CTRL, d);
            `CHK(d, c0 & 16'h03ff)
        end
        for (int i = 0; i < 4; i++) begin
            lv = 2'(i);
            wr(dpw_pkg::OFF_CTRL, 16'h0380 | 16'(lv));
            repeat (3) @(posedge clk_sys_i);
            #1;
            `CHK(pwm_a_o, lv[1])
            `CHK(pwm_b_o, lv[0])
        end
        for (int s = 0; s < 4; s++) begin
            wr(dpw_pkg::OFF_CTRL, 16'h0080 | 16'(s << 4));
            repeat (4) @(posedge clk_sys_i);
            meas(16 << s, ha, hb);
            `CHK(ha, 8 << s)
        end
        for (int s = 0; s < 7; s++) begin
            wr(dpw_pkg::OFF_CTRL, 16'(s << 4));
            repeat (4) @(posedge clk_sys_i);
            rd(dpw_pkg::OFF_COUNT, c0);
            repeat ((8 << s) - 2) @(posedge clk_sys_i);
            rd(dpw_pkg::OFF_COUNT, c1);
            `CHK(16'(c1 - c0), ticks(s, 8 << s))
        end
        wr(dpw_pkg::OFF_CTRL, 16'h0070);
        rd(dpw_pkg::OFF_COUNT, c0);
        repeat (8) begin
            repeat (5) @(posedge clk_sys_i);
            ext_prescale_clk_i <= 1'b1;
            repeat (5) @(posedge clk_sys_i);
            ext_prescale_clk_i <= 1'b0;
        end
        repeat (10) @(posedge clk_sys_i);
        rd(dpw_pkg::OFF_COUNT, c1);
        `CHK(16'(c1 - c0), 16'h0008)
        wr(dpw_pkg::OFF_CTRL, 16'h0000);
        dv = '{8'h00, 8'h80, 8'hff, 8'($urandom)};
        foreach (dv[i]) begin
            da = dv[i];
            db = 8'($urandom);
            wr(dpw_pkg::OFF_DUTY_A, {8'h00, da});
            wr(dpw_pkg::OFF_DUTY_B, {8'h00, db});
            repeat (530) @(posedge clk_sys_i);
            rd(dpw_pkg::OFF_SHADOW_A, d);
            `CHK(d, {8'h00, da})
            rd(dpw_pkg::OFF_SHADOW_B, d);
            `CHK(d, {8'h00, db})
            meas(512, ha, hb);
            `CHK(ha, high_clk(da, 512))
            `CHK(hb, high_clk(db, 512))
        end
        wr(dpw_pkg::OFF_CTRL, 16'h0004);
        repeat (2) @(posedge clk_sys_i);
        meas(65536, ha, hb);
        `CHK(hb, high_clk(db, 65536))
        `CHK(ha, high_clk(da, 65536))
        results();
    end
endmodule
`default_nettype wire
